// File: trm_pkg.sv
package trm_pkg;
    localparam logic [11:0] OFF_IN_OBSERVE  = 12'hEF8;
    localparam logic [11:0] OFF_OUT_DRIVE   = 12'hEFC;
    localparam logic [11:0] OFF_MODE_CTRL   = 12'hF00;
    localparam logic [11:0] OFF_CLAIM_SET   = 12'hFA0;
    localparam logic [11:0] OFF_CLAIM_CLR   = 12'hFA4;
    localparam logic [11:0] OFF_UNLOCK_KEY  = 12'hFB0;
    localparam logic [11:0] OFF_LOCK_STATUS = 12'hFB4;
    localparam logic [11:0] OFF_AUTH_STATUS = 12'hFB8;

    localparam logic [31:0] UNLOCK_KEY_VALUE = 32'hC5ACCE55;
    localparam int          INTEG_ENABLE_BIT = 0;
    localparam int          LOCK_PRESENT_BIT = 0;
    localparam int          LOCK_LOCKED_BIT  = 1;
    localparam int          LOCK_TYPE_BIT    = 2;
    localparam int          CLAIM_BITS       = 4;
    localparam logic [2:0]  HS_OUT_RESET     = 3'h0;
    localparam logic [3:0]  CLAIM_RESET      = 4'h0;
    // Two-bit field positions in the authentication status word
    localparam int          AUTH_NSI_POS     = 0;
    localparam int          AUTH_NSNI_POS    = 2;
    localparam int          AUTH_SI_POS      = 4;
    localparam int          AUTH_SNI_POS     = 6;
endpackage : trm_pkg

// File: trm_hs_mux.sv
`timescale 1ns/1ps
`default_nettype none
module trm_hs_mux (
    // Mode select
    input  wire logic       integ_mode,
    // Functional and test sources
    input  wire logic [2:0] func_out,
    input  wire logic [2:0] drive_bits,
    // Pins
    output logic      [2:0] pin_out
);
    // Test drive replaces functional drive only in integration mode
    assign pin_out = integ_mode ? drive_bits : func_out;
endmodule : trm_hs_mux
`default_nettype wire

// File: trm_regs.sv
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Reset leaves functional mode; enable bit 1 selects integration, 0 returns.
// - In integration mode, observe register bits 0-2 show live handshake inputs.
// - In integration mode, drive register bits 0-2 drive handshake outputs.
// - Writing 1 sets a claim bit; reading set register shows implemented bits.
// - Claim bits are storage only and affect nothing else.
// - Writing 1 clears a claim bit; reading clear register shows claim bits.
// - Key value unlocks writes; any other value written relocks.
// - While locked, control writes are ignored except the key; reads allowed.
// - Lock status bit 0 says lock exists; without it key writes ignored.
// - Lock status bit 1 shows locked state, 1 blocking control writes.
// - Lock status bit 2 shows key register width, 0 meaning 32 bits.
// - Lock gates control-register writes and the drive register writes alike.
// - Auth status two-bit fields report two debug levels implemented by default.
// - Fourth auth field reports secure non-invasive debug not implemented by default.
module trm_regs #(
    parameter bit         LOCK_PRESENT = 1'b1,
    parameter logic [1:0] NSI_IMPL     = 2'h1,
    parameter logic [1:0] NSNI_IMPL    = 2'h1,
    parameter logic [1:0] SI_IMPL      = 2'h0,
    parameter logic [1:0] SNI_IMPL     = 2'h0
) (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // Wishbone slave
    input  wire logic        WB_CYC,
    input  wire logic        WB_STB,
    input  wire logic        WB_WE,
    input  wire logic [11:0] WB_ADR,
    input  wire logic [3:0]  WB_SEL,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK,
    // Handshake inputs
    input  wire logic        OUT_PORT0_READY_IN,
    input  wire logic        OUT_PORT1_READY_IN,
    input  wire logic        IN_PORT_VALID_IN,
    // Functional handshake outputs from the replication logic
    input  wire logic        FUNC_PORT0_VALID,
    input  wire logic        FUNC_PORT1_VALID,
    input  wire logic        FUNC_IN_READY,
    // Handshake outputs
    output logic             OUT_PORT0_VALID_OUT,
    output logic             OUT_PORT1_VALID_OUT,
    output logic             IN_PORT_READY_OUT,
    // Mode indication
    output logic             INTEG_MODE
);
    initial begin
        if (NSI_IMPL > 2'h1 || NSNI_IMPL > 2'h1 || SI_IMPL > 2'h1 ||
            SNI_IMPL > 2'h1) begin
            $error("trm_regs: debug level fields take 0 or 1");
        end
    end

    logic        integ_ff;
    logic [2:0]  drive_ff;
    logic [3:0]  claim_ff;
    logic        locked_ff;
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic [2:0]  pin_out;
    logic        req;
    logic        wr_take;
    logic        ctrl_wr_ok;
    logic        full_word;

    // One-cycle answer: ack in the cycle after the request is seen
    assign req       = WB_CYC && WB_STB && !ack_ff;
    assign wr_take   = req && WB_WE;
    assign full_word = (WB_SEL == 4'hF);
    assign ctrl_wr_ok = wr_take && !locked_ff;

    function automatic logic [31:0] zx3(input logic [2:0] v);
        zx3 = {29'h0, v};
    endfunction : zx3

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            integ_ff <= 1'b0;
        end else if (ctrl_wr_ok && WB_SEL[0] &&
                     WB_ADR == trm_pkg::OFF_MODE_CTRL) begin
            integ_ff <= WB_DAT_I[trm_pkg::INTEG_ENABLE_BIT];
        end
    end

    // Drive bits keep their value whatever the mode
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            drive_ff <= trm_pkg::HS_OUT_RESET;
        end else if (ctrl_wr_ok && WB_SEL[0] &&
                     WB_ADR == trm_pkg::OFF_OUT_DRIVE) begin
            drive_ff <= WB_DAT_I[2:0];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            claim_ff <= trm_pkg::CLAIM_RESET;
        end else if (ctrl_wr_ok && WB_SEL[0] &&
                     WB_ADR == trm_pkg::OFF_CLAIM_SET) begin
            claim_ff <= claim_ff | WB_DAT_I[3:0];
        end else if (ctrl_wr_ok && WB_SEL[0] &&
                     WB_ADR == trm_pkg::OFF_CLAIM_CLR) begin
            claim_ff <= claim_ff & ~WB_DAT_I[3:0];
        end
    end

    // Partial-lane key writes count as "other value" and relock
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            locked_ff <= LOCK_PRESENT;
        end else if (LOCK_PRESENT && wr_take &&
                     WB_ADR == trm_pkg::OFF_UNLOCK_KEY) begin
            locked_ff <= !(full_word &&
                           WB_DAT_I == trm_pkg::UNLOCK_KEY_VALUE);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rdata_ff <= 32'h0;
        end else if (req && !WB_WE) begin
            unique case (WB_ADR)
                trm_pkg::OFF_IN_OBSERVE:
                    rdata_ff <= integ_ff ? zx3({IN_PORT_VALID_IN,
                                OUT_PORT1_READY_IN,
                                OUT_PORT0_READY_IN}) : 32'h0;
                trm_pkg::OFF_OUT_DRIVE:
                    rdata_ff <= zx3(drive_ff);
                trm_pkg::OFF_MODE_CTRL:
                    rdata_ff <= {31'h0, integ_ff};
                trm_pkg::OFF_CLAIM_SET:
                    rdata_ff <= {28'h0, {trm_pkg::CLAIM_BITS{1'b1}}};
                trm_pkg::OFF_CLAIM_CLR:
                    rdata_ff <= {28'h0, claim_ff};
                trm_pkg::OFF_LOCK_STATUS: begin
                    rdata_ff <= 32'h0;
                    rdata_ff[trm_pkg::LOCK_PRESENT_BIT] <= LOCK_PRESENT;
                    rdata_ff[trm_pkg::LOCK_LOCKED_BIT]  <= locked_ff;
                    rdata_ff[trm_pkg::LOCK_TYPE_BIT]    <= 1'b0;
                end
                trm_pkg::OFF_AUTH_STATUS: begin
                    rdata_ff <= 32'h0;
                    rdata_ff[trm_pkg::AUTH_NSI_POS +: 2]  <= NSI_IMPL;
                    rdata_ff[trm_pkg::AUTH_NSNI_POS +: 2] <= NSNI_IMPL;
                    rdata_ff[trm_pkg::AUTH_SI_POS +: 2]   <= SI_IMPL;
                    rdata_ff[trm_pkg::AUTH_SNI_POS +: 2]  <= SNI_IMPL;
                end
                default:
                    rdata_ff <= 32'h0;
            endcase
        end
    end

    // Claim bits feed no logic beyond the read path
    trm_hs_mux u_mux (
        .integ_mode (integ_ff),
        .func_out   ({FUNC_IN_READY, FUNC_PORT1_VALID, FUNC_PORT0_VALID}),
        .drive_bits (drive_ff),
        .pin_out    (pin_out)
    );

    assign OUT_PORT0_VALID_OUT = pin_out[0];
    assign OUT_PORT1_VALID_OUT = pin_out[1];
    assign IN_PORT_READY_OUT   = pin_out[2];
    assign INTEG_MODE          = integ_ff;
    assign WB_ACK              = ack_ff;
    assign WB_DAT_O            = rdata_ff;

    a_ack_one_cycle: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (WB_CYC && WB_STB && !WB_ACK) |=> WB_ACK)
        else $error("ack missing after request");
    a_reset_mode: assert property (@(posedge CORE_CLK)
        !RST_N |=> !INTEG_MODE)
        else $error("mode not functional after reset");
    a_drive_pins: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        INTEG_MODE |-> {IN_PORT_READY_OUT, OUT_PORT1_VALID_OUT,
                        OUT_PORT0_VALID_OUT} == drive_ff)
        else $error("test drive not on pins");
    a_func_pins: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !INTEG_MODE |-> OUT_PORT0_VALID_OUT == FUNC_PORT0_VALID &&
                        OUT_PORT1_VALID_OUT == FUNC_PORT1_VALID &&
                        IN_PORT_READY_OUT == FUNC_IN_READY)
        else $error("functional drive not on pins");
    a_lock_blocks: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (locked_ff && wr_take && WB_ADR != trm_pkg::OFF_UNLOCK_KEY) |=>
        $stable(integ_ff) && $stable(claim_ff) && $stable(drive_ff))
        else $error("write passed while locked");
    a_unlock_key: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (LOCK_PRESENT && wr_take && WB_ADR == trm_pkg::OFF_UNLOCK_KEY)
        |=> locked_ff == !($past(full_word) &&
            $past(WB_DAT_I) == trm_pkg::UNLOCK_KEY_VALUE))
        else $error("key handling wrong");
    a_claim_set: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (ctrl_wr_ok && WB_SEL[0] && WB_ADR == trm_pkg::OFF_CLAIM_SET)
        |=> claim_ff == ($past(claim_ff) | $past(WB_DAT_I[3:0])))
        else $error("claim set wrong");
    a_claim_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (ctrl_wr_ok && WB_SEL[0] && WB_ADR == trm_pkg::OFF_CLAIM_CLR)
        |=> claim_ff == ($past(claim_ff) & ~$past(WB_DAT_I[3:0])))
        else $error("claim clear wrong");
    a_lock_status: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (req && !WB_WE && WB_ADR == trm_pkg::OFF_LOCK_STATUS) |=>
        WB_DAT_O[2:0] == {1'b0, locked_ff, LOCK_PRESENT})
        else $error("lock status read wrong");
    a_ack_drop: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        WB_ACK |=> !WB_ACK)
        else $error("ack held longer than one cycle");
    a_observe_live: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (req && !WB_WE && integ_ff && WB_ADR == trm_pkg::OFF_IN_OBSERVE)
        |=> WB_DAT_O[2:0] == $past({IN_PORT_VALID_IN, OUT_PORT1_READY_IN,
                                    OUT_PORT0_READY_IN}))
        else $error("observe register not live");
    a_claim_impl: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (req && !WB_WE && WB_ADR == trm_pkg::OFF_CLAIM_SET)
        |=> WB_DAT_O == 32'h0000000F)
        else $error("claim implemented bits wrong");
endmodule : trm_regs
`default_nettype wire

// File: trm_trace_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Trace sources and sinks seen by the replicator during integration test
module trm_trace_peer (
    // Clock
    input  wire logic       clk,
    // Levels requested by the bench: {in valid, port1 ready, port0 ready}
    input  wire logic [2:0] lvl,
    // Handshake lines toward the replicator
    output logic            rdy0,
    output logic            rdy1,
    output logic            vld_s
);
    // Levels change only just after an edge, like real logic
    always_ff @(posedge clk) begin
        {vld_s, rdy1, rdy0} <= lvl;
    end
endmodule : trm_trace_peer
`default_nettype wire

// File: trace_replicator_mgmt_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module trace_replicator_mgmt_regs_tb;
    logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack;
    logic [11:0] adr = 12'h000;
    logic [31:0] dat = 32'h0, dat_o, q;
    logic [2:0]  lvl = 3'h0, func = 3'h0;
    logic [3:0]  sel = 4'hF;
    logic        r0, r1, vs, v0, v1, rs, imode;
    int          mismatches = 0, check_count = 0;

    always #2 clk = ~clk;

    trm_trace_peer i_trm_trace_peer (.clk(clk), .lvl(lvl), .rdy0(r0),
        .rdy1(r1), .vld_s(vs));
    trm_regs i_trm_regs (.CORE_CLK(clk), .RST_N(rst_n), .WB_CYC(cyc),
        .WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel),
        .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK(ack),
        .OUT_PORT0_READY_IN(r0), .OUT_PORT1_READY_IN(r1),
        .IN_PORT_VALID_IN(vs), .FUNC_PORT0_VALID(func[0]),
        .FUNC_PORT1_VALID(func[1]), .FUNC_IN_READY(func[2]),
        .OUT_PORT0_VALID_OUT(v0), .OUT_PORT1_VALID_OUT(v1),
        .IN_PORT_READY_OUT(rs), .INTEG_MODE(imode));

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Classic single cycle; the wait is bounded by its own count
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dat_o;
        cyc <= 1'b0; stb <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            test_done();
        end
    endtask : wb

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd

    task automatic pins(input logic [2:0] e);
        @(negedge clk);
        chk({29'h0, rs, v1, v0}, {29'h0, e});
    endtask : pins

    task automatic t_reset;
        rd(trm_pkg::OFF_IN_OBSERVE, 32'h0);
        rd(trm_pkg::OFF_OUT_DRIVE, 32'h0);
        rd(trm_pkg::OFF_MODE_CTRL, 32'h0);
        rd(trm_pkg::OFF_CLAIM_SET, 32'hF);
        rd(trm_pkg::OFF_CLAIM_CLR, 32'h0);
        rd(trm_pkg::OFF_LOCK_STATUS, 32'h3);
        rd(trm_pkg::OFF_AUTH_STATUS, 32'h5);
        rd(12'h004, 32'h0);
    endtask : t_reset

    task automatic t_lock;
        wb(1'b1, trm_pkg::OFF_MODE_CTRL, 32'h1);
        rd(trm_pkg::OFF_MODE_CTRL, 32'h0);
        wb(1'b1, trm_pkg::OFF_UNLOCK_KEY, trm_pkg::UNLOCK_KEY_VALUE);
        rd(trm_pkg::OFF_LOCK_STATUS, 32'h1);
    endtask : t_lock

    task automatic t_func;
        func <= 3'h6;
        lvl <= 3'h5;
        wb(1'b1, trm_pkg::OFF_OUT_DRIVE, 32'h7);
        pins(3'h6);
        rd(trm_pkg::OFF_OUT_DRIVE, 32'h7);
        rd(trm_pkg::OFF_IN_OBSERVE, 32'h0);
    endtask : t_func

    task automatic t_integ;
        wb(1'b1, trm_pkg::OFF_MODE_CTRL, 32'h1);
        pins(3'h7);
        chk({31'h0, imode}, 32'h1);
        wb(1'b1, trm_pkg::OFF_OUT_DRIVE, 32'h2);
        pins(3'h2);
        rd(trm_pkg::OFF_IN_OBSERVE, 32'h5);
        lvl <= 3'h2;
        rd(trm_pkg::OFF_IN_OBSERVE, 32'h2);
        wb(1'b1, trm_pkg::OFF_MODE_CTRL, 32'h0);
        pins(3'h6);
    endtask : t_integ

    task automatic t_claim;
        wb(1'b1, trm_pkg::OFF_CLAIM_SET, 32'h5);
        rd(trm_pkg::OFF_CLAIM_CLR, 32'h5);
        wb(1'b1, trm_pkg::OFF_CLAIM_CLR, 32'h1);
        rd(trm_pkg::OFF_CLAIM_CLR, 32'h4);
        rd(trm_pkg::OFF_CLAIM_SET, 32'hF);
        pins(3'h6);
    endtask : t_claim

    task automatic t_relock;
        sel <= 4'h7;
        wb(1'b1, trm_pkg::OFF_UNLOCK_KEY, trm_pkg::UNLOCK_KEY_VALUE);
        sel <= 4'hF;
        rd(trm_pkg::OFF_LOCK_STATUS, 32'h3);
        wb(1'b1, trm_pkg::OFF_UNLOCK_KEY, 32'h0);
        rd(trm_pkg::OFF_LOCK_STATUS, 32'h3);
        wb(1'b1, trm_pkg::OFF_CLAIM_CLR, 32'hF);
        rd(trm_pkg::OFF_CLAIM_CLR, 32'h4);
    endtask : t_relock

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_lock();
        t_func();
        t_integ();
        t_claim();
        t_relock();
        test_done();
    end

    initial begin
        #20000;
        mismatches++;
        test_done();
    end
endmodule : trace_replicator_mgmt_regs_tb
`default_nettype wire
